// ---- hw/sfrp_regs.vh ----
/*
  Constants of the status flag and row pointer block: system register
  offsets, flag positions, reset values and operation codes.
  Assumes inclusion by bare name from the design files of the block.
*/
`ifndef SFRP_REGS_VH
`define SFRP_REGS_VH

// ==========================================
// system register offsets (low 7 address bits)
`define SFRP_ADDR_RPH   7'h7D
`define SFRP_ADDR_RPL   7'h7E
`define SFRP_ADDR_PSW   7'h7F

// ==========================================
// flag positions
`define SFRP_BIT_BCD    0
`define SFRP_BIT_IXE    0
`define SFRP_BIT_Z      1
`define SFRP_BIT_CY     2
`define SFRP_BIT_CMP    3

// ==========================================
// reset values
`define SFRP_RST_RPH    1'h0
`define SFRP_RST_RPL    4'h0
`define SFRP_RST_PSW    4'h0

// ==========================================
// working register row geometry
`define SFRP_GR_COLS    16
`define SFRP_BANK_PAD   3'h0

// ==========================================
// operation codes of the instruction at hand
`define SFRP_OP_NONE    4'h0
`define SFRP_OP_ADD     4'h1
`define SFRP_OP_ADDC    4'h2
`define SFRP_OP_SUB     4'h3
`define SFRP_OP_SUBC    4'h4
`define SFRP_OP_AND     4'h5
`define SFRP_OP_OR      4'h6
`define SFRP_OP_XOR     4'h7
`define SFRP_OP_MOV     4'h8
`define SFRP_OP_ROTATE_RIGHT_THROUGH_CARRY    4'h9
`define SFRP_OP_BTEST   4'hA

// ==========================================
// decimal correction
`define SFRP_BCD_MAX    5'h09
`define SFRP_BCD_ADJ    4'h6

`endif

// ---- hw/sfrp_alu.v ----
/*
  Four-bit arithmetic and logic unit of the status flag block:
  binary and decimal add and subtract, logic, move and rotate.
  Assumes operands and the carry flag come from the same clock domain;
  the unit is purely combinational.
*/
`timescale 1ns/1ps
`include "sfrp_regs.vh"

module sfrp_alu (
  input  wire [3:0] opCode,
  input  wire [3:0] opA,
  input  wire [3:0] opB,
  input  wire       carryIn,
  input  wire       bcdMode,
  output reg  [3:0] aluRes,
  output reg        aluCout
);

  reg [4:0] sum;
  reg [4:0] diff;
  reg       cUse;

  // ==========================================
  // result selection
  // decimal mode only touches add and subtract
  always @* begin
    cUse = (opCode == `SFRP_OP_ADDC) || (opCode == `SFRP_OP_SUBC);
    sum  = {1'b0, opA} + {1'b0, opB} + {4'h0, cUse & carryIn};
    diff = {1'b0, opA} - {1'b0, opB} - {4'h0, cUse & carryIn};
    aluRes  = opB;
    aluCout = carryIn;
    case (opCode)
      `SFRP_OP_ADD, `SFRP_OP_ADDC: begin
        if (bcdMode && (sum > `SFRP_BCD_MAX)) begin
          aluRes  = sum[3:0] + `SFRP_BCD_ADJ;
          aluCout = 1'b1;
        end else begin
          aluRes  = sum[3:0];
          aluCout = sum[4];
        end
      end
      `SFRP_OP_SUB, `SFRP_OP_SUBC: begin
        // borrow shows as bit 4 of the difference
        if (bcdMode && diff[4]) begin
          aluRes = diff[3:0] - `SFRP_BCD_ADJ;
        end else begin
          aluRes = diff[3:0];
        end
        aluCout = diff[4];
      end
      `SFRP_OP_AND:  aluRes = opA & opB;
      `SFRP_OP_OR:   aluRes = opA | opB;
      `SFRP_OP_XOR:  aluRes = opA ^ opB;
      `SFRP_OP_MOV:  aluRes = opB;
      `SFRP_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        aluRes  = {carryIn, opA[3:1]};
        aluCout = opA[0];
      end
      default: begin
        aluRes  = opB;
        aluCout = carryIn;
      end
    endcase
  end

endmodule

// ---- hw/sfrp_core.v ----
/*
  Status word and working register row pointer of a 4-bit core:
  flag update, result write-back gating, address forming and the
  data-memory view of the three system locations it owns.
  Assumes the core sequencer presents one instruction at a time with
  instrEnd pulsed for one cycle at its last clock, all on mclk.
  Owned locations are read back through rdData_r; other results leave on
  the registered write port unless compare mode holds them back.
*/
`timescale 1ns/1ps
`include "sfrp_regs.vh"

module sfrp_core (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        instrEnd,
  input  wire        ctxSaved,
  input  wire [3:0]  opCode,
  input  wire        dstIsReg,
  input  wire [3:0]  regCol,
  input  wire [10:0] memAddr,
  input  wire [10:0] ixVal,
  input  wire [3:0]  opA,
  input  wire [3:0]  opB,
  input  wire [10:0] rdAddr,
  output wire [10:0] grAddr,
  output wire [10:0] memEffAddr,
  output wire [10:0] dstAddr,
  output wire        bcdFlag,
  output wire        cmpFlag,
  output wire        cyFlag,
  output wire        zFlag,
  output wire        ixeFlag,
  output reg  [10:0] wbAddr_r,
  output reg  [3:0]  wbData_r,
  output reg         wbWe_r,
  output reg  [3:0]  rdData_r,
  output reg         rdHit_r
);

  // ==========================================
  // decode helpers

  // system locations repeat in every bank, so only the
  // low seven address bits take part in the match
  function sysHit;
    input [10:0] addr;
    input [6:0]  loc;
    begin
      sysHit = (addr[6:0] == loc);
    end
  endfunction

  // nibble value of an owned location, zero elsewhere
  function [3:0] sysRead;
    input [10:0] addr;
    input        row_pointer_high_nibble;
    input [3:0]  row_pointer_low_and_decimal;
    input [3:0]  program_status_flags;
    begin
      if (sysHit(addr, `SFRP_ADDR_RPH)) begin
        sysRead = {3'h0, row_pointer_high_nibble};
      end else if (sysHit(addr, `SFRP_ADDR_RPL)) begin
        sysRead = row_pointer_low_and_decimal;
      end else if (sysHit(addr, `SFRP_ADDR_PSW)) begin
        sysRead = program_status_flags;
      end else begin
        sysRead = 4'h0;
      end
    end
  endfunction

  // any of the three owned locations
  function sysOwned;
    input [10:0] addr;
    begin
      sysOwned = sysHit(addr, `SFRP_ADDR_RPH) |
                 sysHit(addr, `SFRP_ADDR_RPL) |
                 sysHit(addr, `SFRP_ADDR_PSW);
    end
  endfunction

  // add and subtract, with or without carry
  function opIsArith;
    input [3:0] op;
    begin
      opIsArith = (op == `SFRP_OP_ADD)  ||
                  (op == `SFRP_OP_ADDC) ||
                  (op == `SFRP_OP_SUB)  ||
                  (op == `SFRP_OP_SUBC);
    end
  endfunction

  // logic and plain move: write back, touch no flag
  function opIsLogic;
    input [3:0] op;
    begin
      opIsLogic = (op == `SFRP_OP_AND) ||
                  (op == `SFRP_OP_OR)  ||
                  (op == `SFRP_OP_XOR) ||
                  (op == `SFRP_OP_MOV);
    end
  endfunction

  // zero flag after an arithmetic result; a zero result
  // under compare keeps the old flag, so chained compares
  // can only ever clear it
  function zeroNext;
    input [3:0] res;
    input       cmp;
    input       zOld;
    begin
      if (res != 4'h0) begin
        zeroNext = 1'b0;
      end else if (!cmp) begin
        zeroNext = 1'b1;
      end else begin
        zeroNext = zOld;
      end
    end
  endfunction

  // carry after the instruction: arithmetic and rotate
  // take the unit's carry out, compare mode or not
  function carryNext;
    input [3:0] op;
    input       cout;
    input       cyOld;
    begin
      if (opIsArith(op) || (op == `SFRP_OP_ROTATE_RIGHT_THROUGH_CARRY)) begin
        carryNext = cout;
      end else begin
        carryNext = cyOld;
      end
    end
  endfunction

  // ==========================================
  // state

  reg        rph_r;     // pointer bank bit
  reg [3:0]  rpl_r;     // pointer row bits and decimal flag
  reg [3:0]  psw_r;     // compare, carry, zero, index enable
  reg        rph_nxt;
  reg [3:0]  rpl_nxt;
  reg [3:0]  psw_nxt;
  reg        wbWe_nxt;

  wire [3:0] aluRes;
  wire       aluCout;

  // ==========================================
  // flag views

  assign bcdFlag = rpl_r[`SFRP_BIT_BCD];
  assign cmpFlag = psw_r[`SFRP_BIT_CMP];
  assign cyFlag  = psw_r[`SFRP_BIT_CY];
  assign zFlag   = psw_r[`SFRP_BIT_Z];
  assign ixeFlag = psw_r[`SFRP_BIT_IXE];

  // ==========================================
  // operation classes

  wire isArith = opIsArith(opCode);
  wire isLogic = opIsLogic(opCode);
  wire isRot   = (opCode == `SFRP_OP_ROTATE_RIGHT_THROUGH_CARRY);
  wire isBtest = (opCode == `SFRP_OP_BTEST);

  // ==========================================
  // address forming

  // working row: bank from 7DH.0, row from 7EH[3:1]
  assign grAddr = {`SFRP_BANK_PAD, rph_r, rpl_r[3:1],
                   regCol};

  // index modification is a plain OR, no carry between fields
  assign memEffAddr = ixeFlag ? (memAddr | ixVal)
                              : memAddr;

  // register operand in the row, memory operand anywhere
  assign dstAddr = dstIsReg ? grAddr : memEffAddr;

  // ==========================================
  // arithmetic and logic unit

  sfrp_alu uAlu (
    .opCode  (opCode),
    .opA     (opA),
    .opB     (opB),
    .carryIn (cyFlag),
    .bcdMode (bcdFlag),
    .aluRes  (aluRes),
    .aluCout (aluCout)
  );

  // ==========================================
  // write-back gating

  // compare mode holds back only arithmetic results;
  // rotate and logic still write their destination
  wire writesRes = (isArith & ~cmpFlag) |
                   isLogic | isRot;

  // owned locations are written here and never forwarded
  wire dstRph = writesRes & sysHit(dstAddr, `SFRP_ADDR_RPH);
  wire dstRpl = writesRes & sysHit(dstAddr, `SFRP_ADDR_RPL);
  wire dstPsw = writesRes & sysHit(dstAddr, `SFRP_ADDR_PSW);
  wire dstOwn = writesRes & sysOwned(dstAddr);

  // ==========================================
  // next state of flags and pointer
  always @* begin
    rph_nxt = rph_r;
    rpl_nxt = rpl_r;
    psw_nxt = psw_r;
    if (instrEnd) begin
      if (isArith) begin
        psw_nxt[`SFRP_BIT_Z] = zeroNext(aluRes, cmpFlag,
                                        zFlag);
      end
      // compare mode never holds the carry back
      psw_nxt[`SFRP_BIT_CY] = carryNext(opCode, aluCout,
                                        cyFlag);
      if (isBtest) begin
        psw_nxt[`SFRP_BIT_CMP] = 1'b0;
      end
      // a result stored into an owned location beats
      // every flag update of the same instruction
      if (dstRph) begin
        rph_nxt = aluRes[0];
      end
      if (dstRpl) begin
        rpl_nxt = aluRes;
      end
      if (dstPsw) begin
        psw_nxt = aluRes;
      end
    end
    // context save clears the status word after the stack
    // has taken it; pointer bits are left alone
    if (ctxSaved) begin
      rpl_nxt[`SFRP_BIT_BCD] = 1'b0;
      psw_nxt = `SFRP_RST_PSW;
    end
  end

  // ==========================================
  // flag and pointer registers
  always @(posedge mclk) begin
    if (!rst_n) begin
      rph_r <= `SFRP_RST_RPH;
      rpl_r <= `SFRP_RST_RPL;
      psw_r <= `SFRP_RST_PSW;
    end else begin
      rph_r <= rph_nxt;
      rpl_r <= rpl_nxt;
      psw_r <= psw_nxt;
    end
  end

  // ==========================================
  // result write-back to data memory
  always @* begin
    wbWe_nxt = instrEnd & writesRes & ~dstOwn;
  end

  // registered so the memory sees one clean write pulse
  // one cycle after the instruction ends
  always @(posedge mclk) begin
    if (!rst_n) begin
      wbWe_r   <= 1'b0;
      wbAddr_r <= 11'h000;
      wbData_r <= 4'h0;
    end else begin
      wbWe_r <= wbWe_nxt;
      if (wbWe_nxt) begin
        wbAddr_r <= dstAddr;
        wbData_r <= aluRes;
      end
    end
  end

  // ==========================================
  // data-memory read view of owned locations

  // one cycle of latency; a write in the same cycle
  // shows up on the following read, not this one
  always @(posedge mclk) begin
    if (!rst_n) begin
      rdData_r <= 4'h0;
      rdHit_r  <= 1'b0;
    end else begin
      rdData_r <= sysRead(rdAddr, rph_r, rpl_r,
                          psw_r);
      rdHit_r  <= sysOwned(rdAddr);
    end
  end

  // ==========================================
  // port timing
  // instrEnd edge: flags, pointer and owned locations
  //   all load on it, so the next instruction sees them
  // wbWe_r rises one cycle after instrEnd, for one cycle;
  //   wbAddr_r and wbData_r then hold until the next
  //   write, so a slow memory may latch them late
  // rdData_r and rdHit_r trail rdAddr by one cycle and
  //   show the value from before a same-edge commit
  // ctxSaved beside instrEnd wins: the flags of that
  //   last instruction are lost, which is safe only
  //   because the context was saved before the pulse
  // grAddr, memEffAddr and dstAddr are combinational
  //   from the pointer registers, the index enable flag and the inputs
  // owned locations never leave on the write port, so
  //   the memory behind them must not be relied on

  // ==========================================
  // limitations
  // the pointer may be aimed at unfitted rows of the
  // second bank; nothing here stops it
  // the operand values opA and opB are fetched by the
  // core; for owned locations it uses rdData_r

endmodule

// ---- tb/sfrp_core_monitor.sv ----
/*
  Port monitor of sfrp_core: flag, address and write-back checks.
  Assumes one mclk domain and attachment by the bind at the foot.
*/
`timescale 1ns/1ps
module sfrp_core_monitor (
  input wire        mclk,
  input wire        rst_n,
  input wire        instrEnd,
  input wire        ctxSaved,
  input wire [3:0]  opCode,
  input wire [3:0]  regCol,
  input wire [10:0] memAddr,
  input wire [10:0] ixVal,
  input wire [3:0]  opA,
  input wire [3:0]  opB,
  input wire [10:0] rdAddr,
  input wire [10:0] grAddr,
  input wire [10:0] memEffAddr,
  input wire [10:0] dstAddr,
  input wire        bcdFlag,
  input wire        cmpFlag,
  input wire        cyFlag,
  input wire        zFlag,
  input wire        ixeFlag,
  input wire        wbWe_r,
  input wire [3:0]  rdData_r
);
  // ========
  // helpers
  // owned targets overwrite flags, so flag checks skip them
  wire [4:0] sumBin = {1'b0, opA} + {1'b0, opB};
  wire       ownDst = dstAddr[6:0] >= 7'h7D;
  wire       arith  = opCode >= 4'h1 && opCode <= 4'h4;
  wire       fire   = instrEnd && !ctxSaved;
  wire       anyFlg = bcdFlag | cmpFlag | cyFlag | zFlag | ixeFlag;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ========
  // assertions
  ctx_clear_a: assert property (ctxSaved |=> !anyFlg)
    else $error("flags survive context save");
  row_addr_a: assert property (
    grAddr[10:8] == 3'h0 && grAddr[3:0] == regCol)
    else $error("register address malformed");
  index_or_a: assert property (
    memEffAddr == (ixeFlag ? (memAddr | ixVal) : memAddr))
    else $error("effective address wrong");
  cmp_nowrite_a: assert property (
    fire && cmpFlag && arith |=> !wbWe_r)
    else $error("write-back under compare");
  zero_hold_a: assert property (
    fire && !ownDst && opCode >= 4'h5 && opCode <= 4'h8 |=> $stable(zFlag))
    else $error("zero flag moved by non-arithmetic");
  btest_clr_a: assert property (fire && opCode == 4'hA |=> !cmpFlag)
    else $error("bit test left compare set");
  add_carry_a: assert property (
    fire && !ownDst && !bcdFlag && opCode == 4'h1
    |=> cyFlag == $past(sumBin[4]))
    else $error("carry after add wrong");
  rot_carry_a: assert property (
    fire && !ownDst && opCode == 4'h9 |=> cyFlag == $past(opA[0]))
    else $error("carry after rotate wrong");
  ptr_top_a: assert property (
    rdAddr[6:0] == 7'h7D |=> rdData_r[3:1] == 3'h0)
    else $error("pointer high bits not zero");

  // main scenarios reached
  cover property (fire && cmpFlag && arith);
  cover property (fire && opCode == 4'h9);
  cover property (ctxSaved);
endmodule

bind sfrp_core sfrp_core_monitor uMon (.mclk, .rst_n, .instrEnd, .ctxSaved,
  .opCode, .regCol, .memAddr, .ixVal, .opA, .opB, .rdAddr, .grAddr,
  .memEffAddr, .dstAddr, .bcdFlag, .cmpFlag, .cyFlag, .zFlag, .ixeFlag,
  .wbWe_r, .rdData_r);

// ---- tb/sfrp_core_bench.sv ----
/*
  Self-checking bench of sfrp_core: instructions and owned-location reads.
  Assumes the design files and the port monitor are compiled before it.
*/
`timescale 1ns/1ps
module sfrp_core_bench;
  reg         mclk, rst_n, instrEnd, ctxSaved, dstIsReg;
  reg  [3:0]  opCode, regCol, opA, opB;
  reg  [10:0] memAddr, ixVal, rdAddr;
  wire [10:0] grAddr, memEffAddr, dstAddr, wbAddr_r;
  wire [3:0]  wbData_r, rdData_r;
  wire        bcdFlag, cmpFlag, cyFlag, zFlag, ixeFlag, wbWe_r, rdHit_r;
  integer     badCount, nTests, i;
  // nibbles: opcode, a, b, result, carry, zero
  reg  [23:0] tbl [0:10] = '{24'h134700, 24'h197011, 24'h211300,
    24'h334F10, 24'h454001, 24'h5F3301, 24'h612301, 24'h7F5A01,
    24'h806601, 24'h950211, 24'h940A01};

  sfrp_core DUT (.mclk, .rst_n, .instrEnd, .ctxSaved, .opCode, .dstIsReg,
    .regCol, .memAddr, .ixVal, .opA, .opB, .rdAddr, .grAddr, .memEffAddr,
    .dstAddr, .bcdFlag, .cmpFlag, .cyFlag, .zFlag, .ixeFlag, .wbAddr_r,
    .wbData_r, .wbWe_r, .rdData_r, .rdHit_r);

  // ========
  // tasks
  task chk(input [10:0] seen, input [10:0] want);
    begin
      nTests = nTests + 1;
      if (seen !== want) begin
        badCount = badCount + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
    end
  endtask

  // one instruction; returns after its commit edge has landed
  task run(input [3:0] c, input [3:0] a, input [3:0] b, input [10:0] m);
    begin
      @(posedge mclk);
      opCode <= c;
      opA <= a;
      opB <= b;
      memAddr <= m;
      instrEnd <= 1'b1;
      @(posedge mclk);
      instrEnd <= 1'b0;
      #1;
    end
  endtask

  task rd(input [10:0] a, input [3:0] want);
    begin
      @(posedge mclk);
      rdAddr <= a;
      @(posedge mclk);
      #1;
      chk(rdData_r, want);
    end
  endtask

  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // ========
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // whole run is under a hundred cycles; this is ample
  initial begin
    #50000;
    badCount = badCount + 1;
    conclude;
  end

  // ========
  // main sequence
  initial begin
    {rst_n, instrEnd, ctxSaved, dstIsReg} = 4'h0;
    {opCode, opA, opB} = 12'h000;
    regCol = 4'h5;
    memAddr = 11'h061;
    ixVal = 11'h012;
    rdAddr = 11'h000;
    badCount = 0;
    nTests = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(11'h07D, 4'h0);
    rd(11'h07E, 4'h0);
    rd(11'h07F, 4'h0);
    chk(rdHit_r, 1'b1);
    rd(11'h061, 4'h0);
    chk(rdHit_r, 1'b0);
    // pointer to top row of second bank, column from regCol
    run(4'h8, 4'h0, 4'hF, 11'h07E);
    run(4'h8, 4'h0, 4'hF, 11'h07D);
    chk(grAddr, 11'h0F5);
    rd(11'h07D, 4'h1);
    rd(11'h07E, 4'hF);
    chk(bcdFlag, 1'b1);
    @(posedge mclk) dstIsReg <= 1'b1;
    #1 chk(dstAddr, 11'h0F5);
    @(posedge mclk) dstIsReg <= 1'b0;
    run(4'h8, 4'h0, 4'h0, 11'h07E);
    run(4'h8, 4'h0, 4'h0, 11'h07D);
    // operation codes 1 to 9 in binary mode
    for (i = 0; i < 11; i = i + 1) begin
      run(tbl[i][23:20], tbl[i][19:16], tbl[i][15:12], 11'h061);
      chk(wbWe_r, 1'b1);
      chk(wbAddr_r, 11'h061);
      chk(wbData_r, tbl[i][11:8]);
      chk(cyFlag, tbl[i][4]);
      chk(zFlag, tbl[i][0]);
    end
    // decimal mode adjusts arithmetic only
    run(4'h8, 4'h0, 4'h1, 11'h07E);
    run(4'h1, 4'h5, 4'h8, 11'h061);
    chk(wbData_r, 4'h3);
    chk(cyFlag, 1'b1);
    run(4'h6, 4'h8, 4'h4, 11'h061);
    chk(wbData_r, 4'hC);
    run(4'h8, 4'h0, 4'h0, 11'h07E);
    // compare mode: no write, zero only kept or cleared
    run(4'h8, 4'h0, 4'hA, 11'h07F);
    run(4'h3, 4'h5, 4'h5, 11'h061);
    chk(wbWe_r, 1'b0);
    chk(zFlag, 1'b1);
    run(4'h3, 4'h3, 4'h4, 11'h061);
    chk(cyFlag, 1'b1);
    chk(zFlag, 1'b0);
    run(4'h3, 4'h5, 4'h5, 11'h061);
    chk(wbWe_r, 1'b0);
    chk(zFlag, 1'b0);
    run(4'hA, 4'h0, 4'h0, 11'h061);
    chk(cmpFlag, 1'b0);
    run(4'h3, 4'h5, 4'h5, 11'h061);
    chk(wbWe_r, 1'b1);
    // index modification, then add into the status word
    run(4'h8, 4'h0, 4'h1, 11'h07F);
    chk(ixeFlag, 1'b1);
    run(4'h1, 4'h3, 4'h4, 11'h061);
    chk(wbAddr_r, 11'h073);
    run(4'h1, 4'h1, 4'hF, 11'h07F);
    chk(cyFlag, 1'b0);
    rd(11'h07F, 4'h0);
    // context save clears flags but keeps the pointer
    run(4'h8, 4'h0, 4'hF, 11'h07F);
    run(4'h8, 4'h0, 4'h3, 11'h07E);
    @(posedge mclk) ctxSaved <= 1'b1;
    @(posedge mclk) ctxSaved <= 1'b0;
    rd(11'h07E, 4'h2);
    rd(11'h07F, 4'h0);
    conclude;
  end
endmodule
